/* design/scc_params.svh */
// Constants of the strap capture block: offsets, field positions, resets.
// Assumes inclusion by bare name from the package and the top module.
// How it works
// - Straps latched at reset release, held till reset
// - Strap pins input before capture, normal after
// - Source strap low crystal, high external clock
// - Spread strap low enables, high disables spreading
// - Frequency strap 00/01/10/11 gives 20/25/30/40
// - Isolate high: ignore PHY transmit, float outputs
// - Low-pin interface keeps working while isolated
// - Clearing isolate bit restores PHY data path
// - Active-low reset clears logic asynchronously
// - Output-enable low disables every output driver
// - Aux clock pin carries out-of-band clock in U3
// - Test reset async active low on test logic
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

// -----------------------------------------------------------------
// Register offsets (byte addresses)
// -----------------------------------------------------------------
`define SCC_ADDR_W 12
`define SCC_OFF_STATUS 12'h000
`define SCC_OFF_CTRL 12'h004
`define SCC_OFF_FREQ 12'h008

// -----------------------------------------------------------------
// Strap vector bit positions
// -----------------------------------------------------------------
`define SCC_STRAP_W 7
`define SCC_BIT_REF_SRC 0
`define SCC_BIT_SSC_OFF 1
`define SCC_BIT_PHY_W 2
`define SCC_BIT_ISO 3
`define SCC_BIT_LP_W 4
`define SCC_BIT_FREQ_LO 5
`define SCC_BIT_FREQ_HI 6
// Pins that never drive: the spread strap is input only
`define SCC_PIN_OUT_MASK 7'h7D

// -----------------------------------------------------------------
// Status and control fields, reset values, timing
// -----------------------------------------------------------------
`define SCC_ST_CAPTURED 7
`define SCC_ST_ISOLATED 8
`define SCC_ST_U3 9
`define SCC_CTRL_ISO 0
`define SCC_CTRL_RESET 1'h0
`define SCC_SETTLE_CYCLES 2'h2
`define SCC_FREQ_20 8'h14
`define SCC_FREQ_25 8'h19
`define SCC_FREQ_30 8'h1E
`define SCC_FREQ_40 8'h28

`endif

/* design/scc_pkg.sv */
// Types shared by the strap capture block.
// Assumes scc_params.svh is on the include path.
`include "scc_params.svh"

package scc_pkg;

	// Capture sequencer states
	typedef enum logic [0:0] {
		SCC_ST_SETTLE = 1'b0,
		SCC_ST_RUN = 1'b1
	} scc_state_t;

	// Reference frequency codes as strapped
	typedef enum logic [1:0] {
		SCC_REF_20 = 2'b00,
		SCC_REF_25 = 2'b01,
		SCC_REF_30 = 2'b10,
		SCC_REF_40 = 2'b11
	} scc_ref_freq_t;

	// Frequency code to MHz value for the frequency register
	function automatic logic [7:0] scc_freq_mhz(input scc_ref_freq_t c);
		case (c)
			SCC_REF_20: scc_freq_mhz = `SCC_FREQ_20;
			SCC_REF_25: scc_freq_mhz = `SCC_FREQ_25;
			SCC_REF_30: scc_freq_mhz = `SCC_FREQ_30;
			default: scc_freq_mhz = `SCC_FREQ_40;
		endcase
	endfunction : scc_freq_mhz

endpackage : scc_pkg

/* design/scc_sync.sv */
// Two-flop synchroniser for a vector of pin inputs.
// Assumes each bit is an independent level; no word coherence.
module scc_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	scc_sync_if.sync port
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s1_d;
	logic [W-1:0] s2_q;
	logic [W-1:0] s2_d;

	// Width must be at least one bit
	if (W < 1) begin : g_chk
		$error("scc_sync: W must be at least 1");
	end

	// First stage feeds only the second
	always_comb begin
		s1_d = port.raw;
		s2_d = s1_q;
	end

	// Reset to constants only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
		end
	end

	assign port.synced = s2_q;
endmodule : scc_sync

/* design/scc_sync_if.sv */
// Bundle between the top module and its pin synchroniser.
// Assumes both ends agree on the width W.
interface scc_sync_if #(parameter int W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] synced;

	// Synchroniser end and user end
	modport sync (input raw, output synced);
	modport user (output raw, input synced);
endinterface : scc_sync_if

/* design/scc_top.sv */
// Strap capture, isolate control and output gating with an APB slave.
// Assumes pins reach it raw and are synchronised here; core-side
// signals run on pclk. presetn is the chip reset pin.
//
// Design decisions made here: the address map and register access over APB.
`include "scc_params.svh"

module scc_top #(
	parameter int PIPE_W = 16,
	parameter int K_W = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [`SCC_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`SCC_STRAP_W-1:0] strap_pin_i,
	output logic [`SCC_STRAP_W-1:0] strap_pin_o,
	output logic [`SCC_STRAP_W-1:0] strap_pin_oe,
	input wire logic [`SCC_STRAP_W-1:0] core_pin_drive,
	input wire logic [`SCC_STRAP_W-1:0] core_pin_en,
	output logic [`SCC_STRAP_W-1:0] core_pin_in,
	input wire logic out_enable_pin,
	output logic ref_ext_clock_sel,
	output logic spread_spectrum_en,
	output logic [1:0] ref_freq_sel,
	output logic straps_captured,
	input wire logic [PIPE_W-1:0] pipe_tx_data_i,
	input wire logic [K_W-1:0] pipe_tx_datak_i,
	output logic [PIPE_W-1:0] core_tx_data,
	output logic [K_W-1:0] core_tx_datak,
	input wire logic core_pclk,
	input wire logic [PIPE_W-1:0] core_rx_data,
	input wire logic [K_W-1:0] core_rx_datak,
	input wire logic core_rx_valid,
	output logic pipe_pclk_o,
	output logic [PIPE_W-1:0] pipe_rx_data_o,
	output logic [K_W-1:0] pipe_rx_datak_o,
	output logic pipe_rx_valid_o,
	output logic pipe_out_oe,
	input wire logic ulpi_iso_clear,
	input wire logic link_in_u3,
	input wire logic out_of_band_clock,
	output logic aux_clock_pin,
	output logic aux_clock_oe,
	input wire logic test_logic_reset_n,
	output logic test_logic_active
);
	localparam int SW = `SCC_STRAP_W;
	localparam int SYN_W = SW + 2 + PIPE_W + K_W;

	// ---------------------------------------------------------------
	// Parameter checks
	// ---------------------------------------------------------------
	// Only the 16-bit PHY bus and byte-wise K codes are served
	if (PIPE_W != 16 || K_W != PIPE_W / 8) begin : g_chk
		$error("scc_top: only a 16-bit bus with 2 K bits is supported");
	end

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	scc_sync_if #(.W(SYN_W)) sync_bus ();

	// Strap, output-enable, out-of-band clock and PHY transmit pins pass two flops before any logic reads them
	assign sync_bus.raw = {pipe_tx_datak_i, pipe_tx_data_i,
		out_of_band_clock, out_enable_pin, strap_pin_i};

	scc_sync #(.W(SYN_W)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.port(sync_bus.sync)
	);

	logic [SW-1:0] strap_s;
	logic oe_s;
	logic oob_s;
	logic [PIPE_W-1:0] tx_s;
	logic [K_W-1:0] txk_s;

	// Unpack the synchronised vector
	assign strap_s = sync_bus.synced[SW-1:0];
	assign oe_s = sync_bus.synced[SW];
	assign oob_s = sync_bus.synced[SW+1];
	assign tx_s = sync_bus.synced[SW+2 +: PIPE_W];
	assign txk_s = sync_bus.synced[SW+2+PIPE_W +: K_W];

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic wr_fire;
	logic ctrl_wr;
	logic mapped;

	scc_pkg::scc_state_t state_q;
	scc_pkg::scc_state_t state_d;
	logic [1:0] settle_q;
	logic [1:0] settle_d;
	logic [SW-1:0] strap_q;
	logic [SW-1:0] strap_d;
	logic iso_q;
	logic iso_d;
	logic ssc_en_q;
	logic ssc_en_d;
	scc_pkg::scc_ref_freq_t freq_q;
	scc_pkg::scc_ref_freq_t freq_d;

	// Write lands only at the edge that completes the access
	assign wr_fire = psel & penable & pready_q & pwrite;
	assign ctrl_wr = wr_fire & (paddr == `SCC_OFF_CTRL);
	assign mapped = (paddr == `SCC_OFF_STATUS) |
		(paddr == `SCC_OFF_CTRL) | (paddr == `SCC_OFF_FREQ);

	// One wait state: ready rises in the second access cycle
	always_comb begin
		pready_d = psel & penable & ~pready_q;
		pslverr_d = pready_d & ~mapped;
		prdata_d = 32'h0000_0000;
		if (pready_d && !pwrite) begin
			case (paddr)
				`SCC_OFF_STATUS: begin
					prdata_d[SW-1:0] = strap_q;
					prdata_d[`SCC_ST_CAPTURED] = (state_q == scc_pkg::SCC_ST_RUN);
					prdata_d[`SCC_ST_ISOLATED] = iso_q;
					prdata_d[`SCC_ST_U3] = link_in_u3;
				end
				`SCC_OFF_CTRL: prdata_d[`SCC_CTRL_ISO] = iso_q;
				`SCC_OFF_FREQ: prdata_d[7:0] = scc_pkg::scc_freq_mhz(freq_q);
				default: prdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Bus answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'h0;
			pslverr_q <= 1'h0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;

	// ---------------------------------------------------------------
	// Strap capture and isolate state
	// ---------------------------------------------------------------
	// Settle lets the synchronisers fill with the true pin levels,
	// so the latched value is the level seen at reset release.
	always_comb begin
		state_d = state_q;
		settle_d = settle_q;
		strap_d = strap_q;
		iso_d = iso_q;
		ssc_en_d = ssc_en_q;
		freq_d = freq_q;
		case (state_q)
			scc_pkg::SCC_ST_SETTLE: begin
				settle_d = settle_q + 2'h1;
				if (settle_q == `SCC_SETTLE_CYCLES) begin
					strap_d = strap_s;
					iso_d = strap_s[`SCC_BIT_ISO];
					ssc_en_d = ~strap_s[`SCC_BIT_SSC_OFF];
					freq_d = scc_pkg::scc_ref_freq_t'({strap_s[`SCC_BIT_FREQ_HI],
						strap_s[`SCC_BIT_FREQ_LO]});
					settle_d = 2'h0;
					state_d = scc_pkg::SCC_ST_RUN;
				end
			end
			scc_pkg::SCC_ST_RUN: begin
				// Clears first, so a write of one in the same cycle wins
				if (ulpi_iso_clear) begin
					iso_d = 1'h0;
				end
				if (ctrl_wr) begin
					iso_d = pwdata[`SCC_CTRL_ISO];
				end
				if (ctrl_wr && pwdata[`SCC_CTRL_ISO]) begin
					iso_d = 1'h1;
				end
			end
			default: state_d = scc_pkg::SCC_ST_SETTLE;
		endcase
	end

	// Captured straps stay until the next reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= scc_pkg::SCC_ST_SETTLE;
			settle_q <= 2'h0;
			strap_q <= '0;
			iso_q <= `SCC_CTRL_RESET;
			ssc_en_q <= 1'h0;
			freq_q <= scc_pkg::SCC_REF_20;
		end else begin
			state_q <= state_d;
			settle_q <= settle_d;
			strap_q <= strap_d;
			iso_q <= iso_d;
			ssc_en_q <= ssc_en_d;
			freq_q <= freq_d;
		end
	end

	// Configuration outputs straight from the capture flops
	assign ref_ext_clock_sel = strap_q[`SCC_BIT_REF_SRC];
	assign spread_spectrum_en = ssc_en_q;
	assign ref_freq_sel = freq_q;
	assign straps_captured = (state_q == scc_pkg::SCC_ST_RUN);

	// ---------------------------------------------------------------
	// Pin drivers and data paths
	// ---------------------------------------------------------------
	logic run;
	logic [SW-1:0] spin_o_q;
	logic [SW-1:0] spin_o_d;
	logic [SW-1:0] spin_oe_q;
	logic [SW-1:0] spin_oe_d;
	logic [SW-1:0] cpin_q;
	logic [SW-1:0] cpin_d;
	logic [PIPE_W-1:0] ctx_q;
	logic [PIPE_W-1:0] ctx_d;
	logic [K_W-1:0] ctxk_q;
	logic [K_W-1:0] ctxk_d;
	logic ppclk_q;
	logic ppclk_d;
	logic [PIPE_W-1:0] prx_q;
	logic [PIPE_W-1:0] prx_d;
	logic [K_W-1:0] prxk_q;
	logic [K_W-1:0] prxk_d;
	logic prxv_q;
	logic prxv_d;
	logic poe_q;
	logic poe_d;
	logic aux_q;
	logic aux_d;
	logic aux_oe_q;
	logic aux_oe_d;

	assign run = (state_q == scc_pkg::SCC_ST_RUN);

	// Strap pins stay inputs until capture, then serve the core.
	// Shared low-pin bus bits are not gated by isolate.
	always_comb begin
		spin_o_d = core_pin_drive;
		spin_oe_d = '0;
		cpin_d = '0;
		if (run) begin
			spin_oe_d = core_pin_en & {SW{oe_s}} & `SCC_PIN_OUT_MASK;
			cpin_d = strap_s;
		end
	end

	// Isolate drops transmit data and floats the PHY outputs.
	// The PHY clock copy is only as fast as pclk allows.
	always_comb begin
		ctx_d = iso_q ? '0 : tx_s;
		ctxk_d = iso_q ? '0 : txk_s;
		ppclk_d = core_pclk;
		prx_d = core_rx_data;
		prxk_d = core_rx_datak;
		prxv_d = core_rx_valid;
		poe_d = run & oe_s & ~iso_q;
		aux_d = link_in_u3 & oob_s;
		aux_oe_d = oe_s;
	end

	// Output flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spin_o_q <= '0;
			spin_oe_q <= '0;
			cpin_q <= '0;
			ctx_q <= '0;
			ctxk_q <= '0;
			ppclk_q <= 1'h0;
			prx_q <= '0;
			prxk_q <= '0;
			prxv_q <= 1'h0;
			poe_q <= 1'h0;
			aux_q <= 1'h0;
			aux_oe_q <= 1'h0;
		end else begin
			spin_o_q <= spin_o_d;
			spin_oe_q <= spin_oe_d;
			cpin_q <= cpin_d;
			ctx_q <= ctx_d;
			ctxk_q <= ctxk_d;
			ppclk_q <= ppclk_d;
			prx_q <= prx_d;
			prxk_q <= prxk_d;
			prxv_q <= prxv_d;
			poe_q <= poe_d;
			aux_q <= aux_d;
			aux_oe_q <= aux_oe_d;
		end
	end

	assign strap_pin_o = spin_o_q;
	assign strap_pin_oe = spin_oe_q;
	assign core_pin_in = cpin_q;
	assign core_tx_data = ctx_q;
	assign core_tx_datak = ctxk_q;
	assign pipe_pclk_o = ppclk_q;
	assign pipe_rx_data_o = prx_q;
	assign pipe_rx_datak_o = prxk_q;
	assign pipe_rx_valid_o = prxv_q;
	assign pipe_out_oe = poe_q;
	assign aux_clock_pin = aux_q;
	assign aux_clock_oe = aux_oe_q;

	// ---------------------------------------------------------------
	// Test logic reset
	// ---------------------------------------------------------------
	logic tl_q;
	logic tl_d;

	// Held low in normal use, so this flop then stays cleared
	always_comb begin
		tl_d = 1'h1;
	end

	always_ff @(posedge pclk or negedge test_logic_reset_n) begin
		if (!test_logic_reset_n) begin
			tl_q <= 1'h0;
		end else begin
			tl_q <= tl_d;
		end
	end

	assign test_logic_active = tl_q;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_settle;
		state_q == scc_pkg::SCC_ST_SETTLE && settle_q == `SCC_SETTLE_CYCLES;
	endsequence

	sequence s_captured;
		state_q == scc_pkg::SCC_ST_RUN && strap_q == $past(strap_s);
	endsequence

	a_strap_capture: assert property (s_settle |=> s_captured)
		else $error("straps not latched from pins at capture");

	a_strap_held: assert property (run |=> $stable(strap_q))
		else $error("captured straps changed after capture");

	a_pins_input: assert property (!run |=> strap_pin_oe == '0)
		else $error("strap pin driven before capture");

	// Source and frequency are checked against the pins, not the latch
	a_src_select: assert property (s_settle |=>
		ref_ext_clock_sel == $past(strap_s[`SCC_BIT_REF_SRC]))
		else $error("reference source does not follow strap");

	a_ssc_polarity: assert property (run |->
		spread_spectrum_en != strap_q[`SCC_BIT_SSC_OFF])
		else $error("spread spectrum polarity wrong");

	a_freq_map: assert property (s_settle |=> ref_freq_sel ==
		$past({strap_s[`SCC_BIT_FREQ_HI], strap_s[`SCC_BIT_FREQ_LO]}))
		else $error("frequency select differs from strap");

	a_iso_float: assert property (iso_q |=> !pipe_out_oe
		&& core_tx_data == '0)
		else $error("isolated PHY side still active");

	a_iso_ulpi_on: assert property (iso_q && run && oe_s
		&& core_pin_en[`SCC_BIT_LP_W] |=> strap_pin_oe[`SCC_BIT_LP_W])
		else $error("low-pin bus stopped while isolated");

	a_iso_clear: assert property (ctrl_wr && !pwdata[`SCC_CTRL_ISO]
		&& run ##1 oe_s |=> pipe_out_oe)
		else $error("PHY outputs not restored after clear");

	a_oe_gate: assert property (!oe_s |=> !pipe_out_oe
		&& !aux_clock_oe && strap_pin_oe == '0)
		else $error("output driven while output enable low");

	a_u3_clock: assert property (!link_in_u3 |=> !aux_clock_pin)
		else $error("aux clock active outside U3");

	a_apb_wait: assert property (psel && penable && !pready_q
		|=> pready_q ##1 !pready_q)
		else $error("bus ready not a single wait state");
endmodule : scc_top

/* tb/scc_board.sv */
// Board straps and link controller as seen from the shared strap pins.
// Assumes the device drives a pin only while its strap_pin_oe bit is high.
`include "scc_params.svh"

module scc_board (
	input wire logic [`SCC_STRAP_W-1:0] strap_level,
	input wire logic [`SCC_STRAP_W-1:0] strap_pin_o,
	input wire logic [`SCC_STRAP_W-1:0] strap_pin_oe,
	output logic [`SCC_STRAP_W-1:0] strap_pin_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [`SCC_STRAP_W-1:0] board_level;

	// Width straps are tied low on the board, whatever is asked
	assign board_level = strap_level & 7'h6B;

	// Resistor level wins unless the device drives the pin
	always_comb begin
		for (int i = 0; i < `SCC_STRAP_W; i++) begin
			strap_pin_i[i] = strap_pin_oe[i] ? strap_pin_o[i] : board_level[i];
		end
	end
endmodule : scc_board

/* tb/strap_reset_config_capture_tb.sv */
// Self-checking bench for the strap capture block, with an APB master.
// Assumes scc_params.svh on the include path and scc_board beside it.
`include "scc_params.svh"

module strap_reset_config_capture_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, out_enable_pin = 1'b1, ulpi_iso_clear = 1'b0;
	logic link_in_u3 = 1'b0, out_of_band_clock = 1'b0, core_pclk = 1'b0;
	logic test_logic_reset_n = 1'b0, core_rx_valid = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic [6:0] core_pin_drive = 7'h00, core_pin_en = 7'h00;
	logic [6:0] strap_level = 7'h00, strap_pin_i, strap_pin_o, strap_pin_oe;
	logic [6:0] core_pin_in;
	logic [15:0] pipe_tx_data_i = 16'h0000, core_rx_data = 16'h0000;
	logic [15:0] core_tx_data, pipe_rx_data_o;
	logic [1:0] pipe_tx_datak_i = 2'h0, core_rx_datak = 2'h0, ref_freq_sel;
	logic [1:0] core_tx_datak, pipe_rx_datak_o;
	logic pready, pslverr, ref_ext_clock_sel, spread_spectrum_en;
	logic straps_captured, pipe_pclk_o, pipe_rx_valid_o, pipe_out_oe;
	logic aux_clock_pin, aux_clock_oe, test_logic_active;
	int fails = 0;
	int tests_run = 0;
	int seed = 81829;

	scc_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .strap_pin_i, .strap_pin_o,
		.strap_pin_oe, .core_pin_drive, .core_pin_en, .core_pin_in,
		.out_enable_pin, .ref_ext_clock_sel, .spread_spectrum_en,
		.ref_freq_sel, .straps_captured, .pipe_tx_data_i, .pipe_tx_datak_i,
		.core_tx_data, .core_tx_datak, .core_pclk, .core_rx_data,
		.core_rx_datak, .core_rx_valid, .pipe_pclk_o, .pipe_rx_data_o,
		.pipe_rx_datak_o, .pipe_rx_valid_o, .pipe_out_oe, .ulpi_iso_clear,
		.link_in_u3, .out_of_band_clock, .aux_clock_pin, .aux_clock_oe,
		.test_logic_reset_n, .test_logic_active);
	scc_board board (.strap_level, .strap_pin_o, .strap_pin_oe, .strap_pin_i);

	// 100 MHz clock
	always #5 pclk = ~pclk;

	// -----------------------------------------------------------------
	// Shared tasks
	// -----------------------------------------------------------------
	// One comparison, counted; four-state so unknowns never match
	task check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test

	// APB transfer; request held until pready is seen high at an edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			fails++;
			end_of_test();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb

	// Reset pulse with new straps; the controller keeps its pins off
	task do_reset(input logic [6:0] s);
		int n;
		@(posedge pclk);
		presetn <= 1'b0;
		core_pin_en <= 7'h00;
		strap_level <= s;
		#1;
		check("captured_async", straps_captured, 0);
		@(posedge pclk);
		#1;
		check("oe_in_reset", strap_pin_oe, 0);
		@(posedge pclk);
		presetn <= 1'b1;
		n = 0;
		while (straps_captured !== 1'b1 && n < 10) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 10) begin
			fails++;
			end_of_test();
		end else begin
			repeat (3) @(posedge pclk);
			#1;
		end
	endtask : do_reset

	function automatic logic [7:0] exp_mhz(input logic [1:0] c);
		case (c)
			2'b00: exp_mhz = 8'h14;
			2'b01: exp_mhz = 8'h19;
			2'b10: exp_mhz = 8'h1E;
			default: exp_mhz = 8'h28;
		endcase
	endfunction : exp_mhz

	// Hang guard: counts as a mismatch and ends the run
	initial begin
		repeat (90000) @(posedge pclk);
		fails++;
		end_of_test();
	end

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		logic [31:0] rd;
		logic err;
		logic [6:0] s;
		logic [6:0] n2;
		logic [37:0] tx;
		logic [19:0] v;
		// Every frequency code first, then random straps, isolate off
		for (int i = 0; i < 10; i++) begin
			s = (i < 4) ? {2'(i), 3'b000, i[0], ~i[0]} : 7'($random(seed));
			s = s & 7'h63;
			do_reset(s);
			check("ref_src", ref_ext_clock_sel, s[0]);
			check("spread_en", spread_spectrum_en, !s[1]);
			check("freq_sel", ref_freq_sel, s[6:5]);
			apb(1'b0, `SCC_OFF_FREQ, 32'h0, rd, err);
			check("freq_reg", rd, exp_mhz(s[6:5]));
			apb(1'b0, `SCC_OFF_STATUS, 32'h0, rd, err);
			check("status", rd[9:0], {3'b001, s});
			n2 = 7'($random(seed)) & 7'h63;
			@(posedge pclk);
			strap_level <= n2;
			repeat (4) @(posedge pclk);
			#1;
			check("freq_held", ref_freq_sel, s[6:5]);
			check("pin_in", core_pin_in, n2);
		end
		// Isolate strapped high: PHY side silent, low-pin side alive
		do_reset(7'h08);
		tx[31:0] = $random(seed);
		tx[37:32] = 6'($random(seed));
		@(posedge pclk);
		{pipe_tx_datak_i, pipe_tx_data_i, core_rx_datak, core_rx_valid,
			core_pclk, core_rx_data} <= tx;
		core_pin_en <= 7'h10;
		repeat (4) @(posedge pclk);
		#1;
		check("oe_iso", pipe_out_oe, 0);
		check("lp_iso", strap_pin_oe, 7'h10);
		check("tx_iso", {core_tx_datak, core_tx_data}, 0);
		apb(1'b0, `SCC_OFF_STATUS, 32'h0, rd, err);
		check("status_iso", {err, rd[8:7]}, 3'b011);
		@(posedge pclk);
		ulpi_iso_clear <= 1'b1;
		@(posedge pclk);
		ulpi_iso_clear <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
		check("oe_clear", pipe_out_oe, 1);
		check("tx_clear", {core_tx_datak, core_tx_data}, tx[37:20]);
		check("rx_copy", {pipe_rx_datak_o, pipe_rx_valid_o, pipe_pclk_o,
			pipe_rx_data_o}, tx[19:0]);
		apb(1'b1, `SCC_OFF_CTRL, 32'h1, rd, err);
		repeat (3) @(posedge pclk);
		#1;
		check("oe_set", pipe_out_oe, 0);
		apb(1'b0, `SCC_OFF_CTRL, 32'h0, rd, err);
		check("ctrl_rd", rd, 1);
		apb(1'b1, `SCC_OFF_CTRL, 32'h0, rd, err);
		repeat (3) @(posedge pclk);
		#1;
		check("oe_wr0", pipe_out_oe, 1);
		// Unmapped place refused, read-only place unchanged
		apb(1'b0, 12'h010, 32'h0, rd, err);
		check("unmapped_err", err, 1);
		check("unmapped", rd, 0);
		apb(1'b1, `SCC_OFF_FREQ, 32'hFF, rd, err);
		apb(1'b0, `SCC_OFF_FREQ, 32'h0, rd, err);
		check("freq_ro", rd, 8'h14);
		// Output enable low gates every driver
		@(posedge pclk);
		out_enable_pin <= 1'b0;
		core_pin_en <= 7'h7F;
		core_pin_drive <= 7'($random(seed));
		repeat (4) @(posedge pclk);
		#1;
		check("oe_off", {pipe_out_oe, aux_clock_oe, strap_pin_oe}, 0);
		check("pin_o", strap_pin_o, core_pin_drive);
		@(posedge pclk);
		out_enable_pin <= 1'b1;
		repeat (4) @(posedge pclk);
		#1;
		check("oe_on", {aux_clock_oe, pipe_out_oe}, 2'b11);
		check("pin_oe", strap_pin_oe, `SCC_PIN_OUT_MASK);
		// Out-of-band clock on the aux pin only in U3
		@(posedge pclk);
		core_pin_en <= 7'h00;
		link_in_u3 <= 1'b1;
		v = 20'($random(seed));
		for (int i = 0; i < 20; i++) begin
			@(posedge pclk);
			out_of_band_clock <= v[i];
			#1;
			if (i >= 3) check("aux", aux_clock_pin, v[i-3]);
		end
		@(posedge pclk);
		link_in_u3 <= 1'b0;
		out_of_band_clock <= 1'b1;
		repeat (4) @(posedge pclk);
		#1;
		check("aux_off", aux_clock_pin, 0);
		// Test-logic reset acts without waiting for a clock edge
		@(posedge pclk);
		test_logic_reset_n <= 1'b1;
		repeat (2) @(posedge pclk);
		#1;
		check("test_on", test_logic_active, 1);
		@(posedge pclk);
		test_logic_reset_n <= 1'b0;
		#1;
		check("test_off", test_logic_active, 0);
		end_of_test();
	end
endmodule : strap_reset_config_capture_tb
